// File: logic/dsr_parser.sv
// dyno speed-range command parser: host characters in, range, brake drive and indicators out
module dsr_parser (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // host character stream
    input wire logic [7:0] char_in,
    input wire logic char_valid_in,
    input wire logic talk_in,
    output logic talk_record_out,
    // machine side
    input wire logic brake_switch_in,
    input wire logic [15:0] speed_in,
    output logic [15:0] range_out,
    output logic [15:0] brake_drive_out,
    output dsr_pkg::dsr_leds_t leds_out,
    // register port
    input wire dsr_pkg::dsr_bus_t bus_in,
    output logic [15:0] rdata_out,
    output logic irq_out
);
    `include "dsr_regs.svh"
    logic brake_s1, brake_s2;
    logic [15:0] speed_s1, speed_s2;
    dsr_pkg::dsr_state_t state;
    logic [7:0] buf_mem [0:7];
    logic [3:0] buf_len;
    logic overflow, entry_done, entry_ok;
    logic [15:0] range, setpoint, torque_level, brake_drive, rdata, arg_val;
    logic explicit_range, auto_done, speed_mode, blink_req, blink_phase, torque_mode;
    dsr_pkg::dsr_leds_t leds;
    logic [31:0] blink_cnt;
    logic [`DSR_IRQ_W-1:0] irq_stat, irq_mask, irq_set;
    // pins from the dyno are asynchronous to the parser clock
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            brake_s1 <= 1'b0;
            brake_s2 <= 1'b0;
            speed_s1 <= 16'h0000;
            speed_s2 <= 16'h0000;
        end
        else
        begin
            brake_s1 <= brake_switch_in;
            brake_s2 <= brake_s1;
            speed_s1 <= speed_in;
            speed_s2 <= speed_s1;
        end
    end
    // entry buffer; overflowing entries decode as an error
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state <= dsr_pkg::DSR_IDLE;
            buf_len <= 4'h0;
            overflow <= 1'b0;
        end
        else
        begin
            unique case (state)
                dsr_pkg::DSR_IDLE:
                begin
                    if (char_valid_in && char_in == `DSR_CH_CR)
                        state <= dsr_pkg::DSR_GOT_CR;
                    else if (char_valid_in)
                    begin
                        if (buf_len == `DSR_LINE_MAX)
                            overflow <= 1'b1;
                        else
                            buf_len <= buf_len + 4'h1;
                    end
                end
                dsr_pkg::DSR_GOT_CR:
                begin
                    if (char_valid_in && char_in == `DSR_CH_LF)
                        state <= dsr_pkg::DSR_DECODE;
                    else if (char_valid_in)
                    begin
                        overflow <= 1'b1;
                        state <= dsr_pkg::DSR_IDLE;
                    end
                end
                dsr_pkg::DSR_DECODE:
                begin
                    state <= dsr_pkg::DSR_IDLE;
                    buf_len <= 4'h0;
                    overflow <= 1'b0;
                end
            endcase
        end
    end
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_buf
            always_ff @(posedge ref_clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                    buf_mem[i] <= 8'h00;
                else if (state == dsr_pkg::DSR_IDLE && char_valid_in && char_in != `DSR_CH_CR
                         && buf_len == 4'(i))
                    buf_mem[i] <= char_in;
            end
        end
    endgenerate
    logic arg_ok, has_arg, is_letter_range, is_f, is_n_set, is_n_reset, is_r;
    logic [7:0] cmd;
    always_comb
    begin
        logic [16:0] acc;
        acc = 17'h00000;
        arg_ok = 1'b1;
        cmd = buf_mem[0];
        has_arg = buf_len > 4'h1;
        for (int k = 1; k < 8; k++)
        begin
            if (4'(k) < buf_len)
            begin
                if (buf_mem[k] < `DSR_CH_0 || buf_mem[k] > `DSR_CH_9)
                    arg_ok = 1'b0;
                acc = 17'(acc * 17'd10 + 17'(buf_mem[k] - `DSR_CH_0));
                if (acc > 17'(`DSR_SPEED_MAX))
                    arg_ok = 1'b0;
            end
        end
        arg_val = acc[15:0];
    end
    always_comb
    begin
        is_letter_range = !has_arg && cmd >= `DSR_CH_A && cmd <= `DSR_CH_E;
        is_f = has_arg && arg_ok && cmd == `DSR_CH_F && arg_val >= `DSR_AUTO_MIN;
        is_n_set = has_arg && arg_ok && cmd == `DSR_CH_N;
        is_n_reset = !has_arg && cmd == `DSR_CH_N;
        is_r = !has_arg && cmd == `DSR_CH_R;
        entry_done = state == dsr_pkg::DSR_DECODE;
        entry_ok = entry_done && !overflow && buf_len != 4'h0
                   && (is_letter_range || is_f || is_n_set || is_n_reset || is_r);
    end
    // range selection: explicit commands beat auto ranging
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            range <= `DSR_RANGE_E;
            explicit_range <= 1'b0;
            auto_done <= 1'b0;
        end
        else if (entry_ok && (is_letter_range || is_f))
        begin
            explicit_range <= 1'b1;
            auto_done <= 1'b0;
            unique case (cmd)
                `DSR_CH_A: range <= `DSR_RANGE_A;
                `DSR_CH_B: range <= `DSR_RANGE_B;
                `DSR_CH_C: range <= `DSR_RANGE_C;
                `DSR_CH_D: range <= `DSR_RANGE_D;
                `DSR_CH_E: range <= `DSR_RANGE_E;
                default: range <= arg_val;
            endcase
        end
        else if (entry_ok && (is_n_reset || is_r))
        begin
            explicit_range <= 1'b0;
            auto_done <= 1'b0;
            range <= `DSR_RANGE_E;
        end
        else if (!explicit_range && !auto_done && !brake_s2 && speed_s2 > `DSR_AUTO_MIN)
        begin
            range <= speed_s2;
            auto_done <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            setpoint <= 16'h0000;
            speed_mode <= 1'b0;
            blink_req <= 1'b0;
        end
        else
        begin
            if (entry_ok && is_n_set)
            begin
                setpoint <= arg_val;
                speed_mode <= 1'b1;
            end
            else if (entry_ok && is_n_reset)
                speed_mode <= 1'b0;
            if (entry_ok && is_n_set && !brake_s2)
                blink_req <= 1'b1;
            else if (brake_s2)
                blink_req <= 1'b0;
        end
    end
    // blink timer, a quarter second per phase
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            blink_cnt <= 32'h00000000;
            blink_phase <= 1'b0;
        end
        else if (!blink_req)
        begin
            blink_cnt <= 32'h00000000;
            blink_phase <= 1'b1; // first phase lit, so the flash shows at once
        end
        else if (blink_cnt == 32'(`DSR_BLINK_CYC - 1))
        begin
            blink_cnt <= 32'h00000000;
            blink_phase <= !blink_phase;
        end
        else
            blink_cnt <= blink_cnt + 32'h00000001;
    end
    // brake drive; gain is a plain shift, saturating at full scale
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            brake_drive <= 16'h0000;
        else if (torque_mode)
            brake_drive <= torque_level;
        else if (speed_mode && speed_s2 > setpoint)
            brake_drive <= ((speed_s2 - setpoint) > (16'hffff >> `DSR_GAIN_SHIFT)) ? 16'hffff
                           : 16'((speed_s2 - setpoint) << `DSR_GAIN_SHIFT);
        else
            brake_drive <= 16'h0000;
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            leds <= '0;
            talk_record_out <= 1'b0;
        end
        else
        begin
            if (char_valid_in)
                leds.transfer <= 1'b1;
            else if (entry_done)
                leds.transfer <= 1'b0;
            if (entry_ok)
                leds.error <= 1'b0;
            else if (entry_done)
                leds.error <= 1'b1;
            leds.auto_range <= auto_done;
            leds.bus_speed <= speed_mode;
            if (entry_ok && is_n_set)
                leds.speed_sync <= 1'b1;
            else if (!speed_mode)
                leds.speed_sync <= 1'b0;
            leds.brake <= blink_req ? blink_phase : brake_s2;
            talk_record_out <= talk_in && state == dsr_pkg::DSR_IDLE && buf_len == 4'h0;
        end
    end
    // registers and interrupt; set beats clear
    always_comb
    begin
        irq_set = '0;
        irq_set[`DSR_IRQ_CMD_OK] = entry_ok;
        irq_set[`DSR_IRQ_CMD_ERR] = entry_done && !entry_ok;
        irq_set[`DSR_IRQ_AUTO] = !leds.auto_range && auto_done;
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            torque_mode <= 1'b0;
            torque_level <= 16'h0000;
        end
        else
        begin
            if (bus_in.wr && bus_in.addr == `DSR_ADDR_IRQ_STAT)
                irq_stat <= (irq_stat & ~bus_in.wdata[`DSR_IRQ_W-1:0]) | irq_set;
            else
                irq_stat <= irq_stat | irq_set;
            if (bus_in.wr && bus_in.addr == `DSR_ADDR_IRQ_MASK)
                irq_mask <= bus_in.wdata[`DSR_IRQ_W-1:0];
            if (bus_in.wr && bus_in.addr == `DSR_ADDR_CTRL)
                torque_mode <= bus_in.wdata[`DSR_CTRL_TORQUE_MODE];
            if (bus_in.wr && bus_in.addr == `DSR_ADDR_TORQUE)
                torque_level <= bus_in.wdata;
        end
    end
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rdata <= 16'h0000;
        else if (bus_in.rd)
        begin
            unique case (bus_in.addr)
                `DSR_ADDR_CTRL: rdata <= {15'h0000, torque_mode};
                `DSR_ADDR_STAT: rdata <= {8'h00, explicit_range, speed_mode, 6'(leds)};
                `DSR_ADDR_RANGE: rdata <= range;
                `DSR_ADDR_SETPT: rdata <= setpoint;
                `DSR_ADDR_IRQ_STAT: rdata <= {13'h0000, irq_stat};
                `DSR_ADDR_IRQ_MASK: rdata <= {13'h0000, irq_mask};
                `DSR_ADDR_TORQUE: rdata <= torque_level;
                `DSR_ADDR_DRIVE: rdata <= brake_drive;
                default: rdata <= 16'h0000;
            endcase
        end
        else
            rdata <= 16'h0000;
    end
    assign rdata_out = rdata;
    assign irq_out = |(irq_stat & irq_mask);
    assign range_out = range;
    assign brake_drive_out = brake_drive;
    assign leds_out = leds;
    a_explicit_wins: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        explicit_range && !(entry_ok && (is_letter_range || is_f || is_n_reset || is_r)) |=> $stable(range))
        else $error("range moved under explicit control");
    a_auto_cond: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(auto_done) |-> !$past(explicit_range) && !$past(brake_s2) && $past(speed_s2) > `DSR_AUTO_MIN)
        else $error("auto range without conditions");
    a_auto_led: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(auto_done) |=> leds.auto_range)
        else $error("auto led not lit");
    a_range_led_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        entry_ok && is_letter_range |=> !auto_done ##1 !leds.auto_range)
        else $error("auto led stayed on");
    a_range_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        entry_ok && is_letter_range && cmd == `DSR_CH_A |=> range == `DSR_RANGE_A)
        else $error("range A wrong");
    a_err_led: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        entry_done |=> leds.error == !$past(entry_ok))
        else $error("error led wrong");
    a_setpt_leds: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        entry_ok && is_n_set |=> ##1 leds.bus_speed && leds.speed_sync)
        else $error("speed leds not lit");
    a_n_reset: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        entry_ok && is_n_reset |=> range == `DSR_RANGE_E && !explicit_range && !speed_mode)
        else $error("bare N failed");
    a_xfer_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        entry_done && !char_valid_in |=> !leds.transfer)
        else $error("transfer led stuck");
    a_torque_drv: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        torque_mode |=> brake_drive == $past(torque_level))
        else $error("torque drive wrong");
    c_range_cmd: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) entry_ok && is_f);
    c_setpoint: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) entry_ok && is_n_set);
    c_auto: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) $rose(auto_done));
    c_error: cover property (@(posedge ref_clk_in) disable iff (!arst_n_in) entry_done && !entry_ok);
endmodule : dsr_parser

// File: pkg/dsr_regs.svh
// constants of the dyno speed-range command parser
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH
`define DSR_CH_CR 8'h0d
`define DSR_CH_LF 8'h0a
`define DSR_CH_0 8'h30
`define DSR_CH_9 8'h39
`define DSR_CH_A 8'h41
`define DSR_CH_B 8'h42
`define DSR_CH_C 8'h43
`define DSR_CH_D 8'h44
`define DSR_CH_E 8'h45
`define DSR_CH_F 8'h46
`define DSR_CH_N 8'h4e
`define DSR_CH_R 8'h52
`define DSR_LINE_MAX 4'h8
`define DSR_RANGE_A 16'h07d0
`define DSR_RANGE_B 16'h0fa0
`define DSR_RANGE_C 16'h1f40
`define DSR_RANGE_D 16'h3e80
`define DSR_RANGE_E 16'h7d00
`define DSR_AUTO_MIN 16'h0100
`define DSR_SPEED_MAX 16'h7d00
`define DSR_ADDR_CTRL 4'h0
`define DSR_ADDR_STAT 4'h1
`define DSR_ADDR_RANGE 4'h2
`define DSR_ADDR_SETPT 4'h3
`define DSR_ADDR_IRQ_STAT 4'h4
`define DSR_ADDR_IRQ_MASK 4'h5
`define DSR_ADDR_TORQUE 4'h6
`define DSR_ADDR_DRIVE 4'h7
`define DSR_CTRL_TORQUE_MODE 0
`define DSR_IRQ_CMD_OK 0
`define DSR_IRQ_CMD_ERR 1
`define DSR_IRQ_AUTO 2
`define DSR_IRQ_W 3
`define DSR_BLINK_NS 250000000
`define DSR_CLK_NS 25
`define DSR_BLINK_CYC (`DSR_BLINK_NS / `DSR_CLK_NS)
`define DSR_GAIN_SHIFT 3
`endif

// File: pkg/dsr_pkg.sv
// types of the dyno speed-range command parser
package dsr_pkg;
    typedef enum logic [1:0] {DSR_IDLE, DSR_GOT_CR, DSR_DECODE} dsr_state_t;
    typedef struct packed {
        logic transfer;
        logic error;
        logic auto_range;
        logic bus_speed;
        logic speed_sync;
        logic brake;
    } dsr_leds_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dsr_bus_t;
endpackage : dsr_pkg

// File: testbench/dsr_host_model.sv
// host side model: sends uppercase ascii entries one character per cycle
`include "dsr_regs.svh"
module dsr_host_model (
    // clock
    input wire logic ref_clk_in,
    // character stream to the parser
    output logic [7:0] char_out,
    output logic char_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        char_out = 8'h00;
        char_valid_out = 1'b0;
    end

    task automatic put(input logic [7:0] c);
        @(posedge ref_clk_in);
        char_out <= c;
        char_valid_out <= 1'b1;
    endtask : put

    // returns at the edge that takes the last character
    task automatic send(input string s, input bit term);
        for (int i = 0; i < s.len(); i++)
        begin
            put(s[i]);
        end
        if (term)
        begin
            put(`DSR_CH_CR);
            put(`DSR_CH_LF);
        end
        @(posedge ref_clk_in);
        char_valid_out <= 1'b0;
        // idle data is not held, so a stale byte cannot pass for a new one
        char_out <= ~char_out;
    endtask : send
endmodule : dsr_host_model

// File: testbench/dsr_tb.sv
// self-checking bench of the dyno speed-range command parser
`include "dsr_regs.svh"
`define CHK(g, e) check_val(16'(g), 16'(e))
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string cmd; logic [15:0] rng; logic err;} dsr_row_t;
    logic ref_clk_in, arst_n_in, char_valid_in, talk_in, talk_record_out, brake_switch_in, irq_out;
    logic [7:0] char_in;
    logic [15:0] speed_in, range_out, brake_drive_out, rdata_out, rd_val;
    dsr_pkg::dsr_leds_t leds_out;
    dsr_pkg::dsr_bus_t bus_in;
    int n_mismatch = 0;
    int comparisons = 0;
    // host keeps F within 256..32000 except the refused rows
    dsr_row_t rows [11] = '{'{"A", `DSR_RANGE_A, 1'b0}, '{"B", `DSR_RANGE_B, 1'b0},
        '{"C", `DSR_RANGE_C, 1'b0}, '{"D", `DSR_RANGE_D, 1'b0}, '{"E", `DSR_RANGE_E, 1'b0},
        '{"F00300", 16'h012c, 1'b0}, '{"F255", 16'h012c, 1'b1}, '{"F32001", 16'h012c, 1'b1},
        '{"Z", 16'h012c, 1'b1}, '{"F000000300", 16'h012c, 1'b1}, '{"C", `DSR_RANGE_C, 1'b0}};

    dsr_host_model host (
        .ref_clk_in(ref_clk_in),
        .char_out(char_in),
        .char_valid_out(char_valid_in)
    );

    dsr_parser dut (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(arst_n_in),
        .char_in(char_in),
        .char_valid_in(char_valid_in),
        .talk_in(talk_in),
        .talk_record_out(talk_record_out),
        .brake_switch_in(brake_switch_in),
        .speed_in(speed_in),
        .range_out(range_out),
        .brake_drive_out(brake_drive_out),
        .leds_out(leds_out),
        .bus_in(bus_in),
        .rdata_out(rdata_out),
        .irq_out(irq_out)
    );

    initial
    begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_val

    // decode lands two edges after the terminator, the auto range and bus speed leds one edge later
    task automatic line(input string s);
        host.send(s, 1'b1);
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask : line

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk_in);
        bus_in <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk_in);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk_in);
        bus_in <= '0;
        #1;
        v = rdata_out;
    endtask : rd

    // bounded wait on range (sel 0) or brake drive (sel 1), then compare
    task automatic wait_out(input bit sel, input logic [15:0] e);
        logic [15:0] cur;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk_in);
            #1;
            cur = sel ? brake_drive_out : range_out;
            if (cur === e)
                break;
        end
        `CHK(cur, e);
        // a bound that runs out ends the run
        if (cur !== e)
            stop_test();
    endtask : wait_out

    initial
    begin
        repeat (100000) @(posedge ref_clk_in);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        string rc [2] = '{"R", "N"};
        arst_n_in = 1'b0;
        talk_in = 1'b0;
        brake_switch_in = 1'b0;
        speed_in = 16'h0000;
        bus_in = '0;
        repeat (4) @(posedge ref_clk_in);
        #1;
        `CHK(range_out, `DSR_RANGE_E);
        `CHK(leds_out, 6'h00);
        `CHK(rdata_out, 16'h0000);
        `CHK(irq_out, 1'b0);
        @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        speed_in <= `DSR_AUTO_MIN;
        repeat (20) @(posedge ref_clk_in);
        #1;
        `CHK(range_out, `DSR_RANGE_E);
        `CHK(leds_out.auto_range, 1'b0);
        speed_in <= 16'h0101;
        wait_out(1'b0, 16'h0101);
        // the indicator follows the latched range by one edge
        @(posedge ref_clk_in);
        #1;
        `CHK(leds_out.auto_range, 1'b1);
        foreach (rows[i])
        begin
            line(rows[i].cmd);
            `CHK(range_out, rows[i].rng);
            `CHK(leds_out.error, rows[i].err);
            `CHK(leds_out.auto_range, 1'b0);
            `CHK(leds_out.transfer, 1'b0);
        end
        speed_in <= 16'd3000;
        repeat (20) @(posedge ref_clk_in);
        #1;
        `CHK(range_out, `DSR_RANGE_C);
        talk_in <= 1'b1;
        host.send("B", 1'b0);
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK(leds_out.transfer, 1'b1);
        `CHK(talk_record_out, 1'b0);
        `CHK(range_out, `DSR_RANGE_C);
        line("");
        `CHK(leds_out.transfer, 1'b0);
        `CHK(talk_record_out, 1'b1);
        `CHK(range_out, `DSR_RANGE_B);
        talk_in <= 1'b0;
        line("N1787");
        `CHK(leds_out.bus_speed, 1'b1);
        `CHK(leds_out.speed_sync, 1'b1);
        `CHK(leds_out.brake, 1'b1);
        brake_switch_in <= 1'b1;
        speed_in <= 16'd2000;
        // 213 rpm over the setpoint, gain of eight
        wait_out(1'b1, 16'h06a8);
        wr(`DSR_ADDR_CTRL, 16'h0001);
        wr(`DSR_ADDR_TORQUE, 16'h0123);
        wait_out(1'b1, 16'h0123);
        speed_in <= 16'd5000;
        repeat (10) @(posedge ref_clk_in);
        #1;
        `CHK(brake_drive_out, 16'h0123);
        wr(`DSR_ADDR_CTRL, 16'h0000);
        brake_switch_in <= 1'b0;
        foreach (rc[i])
        begin
            speed_in <= 16'h0000;
            line("A");
            line(rc[i]);
            `CHK(range_out, `DSR_RANGE_E);
            if (i == 1)
                `CHK(leds_out.bus_speed, 1'b0);
            speed_in <= 16'd5000 + 16'(i);
            wait_out(1'b0, 16'd5000 + 16'(i));
            @(posedge ref_clk_in);
            #1;
            `CHK(leds_out.auto_range, 1'b1);
        end
        rd(`DSR_ADDR_RANGE, rd_val);
        `CHK(rd_val, 16'd5001);
        rd(`DSR_ADDR_SETPT, rd_val);
        `CHK(rd_val, 16'd1787);
        rd(4'h8, rd_val);
        `CHK(rd_val, 16'h0000);
        wr(`DSR_ADDR_IRQ_MASK, 16'h0000);
        wr(`DSR_ADDR_IRQ_STAT, 16'h0007);
        line("Z");
        `CHK(irq_out, 1'b0);
        rd(`DSR_ADDR_IRQ_STAT, rd_val);
        `CHK(rd_val & 16'h0002, 16'h0002);
        wr(`DSR_ADDR_IRQ_MASK, 16'h0002);
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK(irq_out, 1'b1);
        wr(`DSR_ADDR_IRQ_STAT, 16'h0002);
        repeat (2) @(posedge ref_clk_in);
        #1;
        `CHK(irq_out, 1'b0);
        stop_test();
    end
endmodule : testbench
